// File: rtl/sfsr_buf.v
// two-entry buffer between array fetch and serial output
`timescale 1ns/1ns
`default_nettype none
module sfsr_buf #(
   parameter W = 8
) (
   input wire mclk,
   input wire rst_n,
   input wire flush,
   input wire in_valid,
   input wire [W-1:0] in_data,
   output reg in_ready,
   output wire out_valid,
   output wire [W-1:0] out_data,
   input wire out_ready
);
   reg [W-1:0] mem_q [0:1];
   reg wp_q;
   reg rp_q;
   reg [1:0] cnt_q;
   wire push = in_valid & in_ready & ~flush;
   wire pop = out_valid & out_ready & ~flush;
   reg [1:0] cnt_d;

   assign out_valid = (cnt_q != 2'd0);
   assign out_data = mem_q[rp_q];

   always @* begin
      cnt_d = cnt_q;
      if (flush)
         cnt_d = 2'd0;
      else if (push & ~pop)
         cnt_d = cnt_q + 2'd1;
      else if (pop & ~push)
         cnt_d = cnt_q - 2'd1;
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'd0;
         in_ready <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         in_ready <= (cnt_d != 2'd2);
         if (flush) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
         end else begin
            if (push)
               wp_q <= ~wp_q;
            if (pop)
               rp_q <= ~rp_q;
         end
      end
   end

   always @(posedge mclk) begin
      if (push)
         mem_q[wp_q] <= in_data;
   end
endmodule // sfsr_buf
`default_nettype wire

// File: rtl/sfsr_core.v
// serial flash status register and read instruction sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sfsr_map.vh"
module sfsr_core #(
   parameter [23:0] TW_CYC = `SFSR_TW_CYC
) (
   input wire mclk,
   input wire rst_n,
   input wire spi_sel_n,
   input wire spi_clk,
   input wire [3:0] io_in,
   output reg [3:0] io_out,
   output reg [3:0] io_oe_n,
   input wire prog_busy,
   output reg arr_req,
   output reg [23:0] arr_addr,
   input wire arr_valid,
   input wire [7:0] arr_data,
   output wire arr_ready,
   output reg [7:0] status_word_low,
   output reg [7:0] status_word_high
);
   localparam [3:0] S_IDLE = 4'd0;
   localparam [3:0] S_OP = 4'd1;
   localparam [3:0] S_ADDR = 4'd2;
   localparam [3:0] S_MODE = 4'd3;
   localparam [3:0] S_DUMMY = 4'd4;
   localparam [3:0] S_DATA = 4'd5;
   localparam [3:0] S_STAT = 4'd6;
   localparam [3:0] S_WRS = 4'd7;
   localparam [3:0] S_END = 4'd8;
   localparam [3:0] S_IGN = 4'd9;
   localparam [7:0] NV_LO = `SFSR_NV_LO_MASK;
   localparam [7:0] NV_HI = `SFSR_NV_HI_MASK;
   // output lane widths
   localparam [1:0] W1 = 2'd0;
   localparam [1:0] W2 = 2'd1;
   localparam [1:0] W4 = 2'd2;
   // ======================================================
   // lane mapping of one output beat
   function [3:0] lanes;
      input [7:0] b;
      input [2:0] ph;
      input [1:0] w;
      reg [7:0] sh;
      begin
         sh = b << ph;
         case (w)
            W1: lanes = {2'b00, sh[7], 1'b0};
            W2: lanes = {2'b00, sh[7], sh[6]};
            default: lanes = sh[7:4];
         endcase
      end
   endfunction

   function [3:0] enables_n;
      input [1:0] w;
      begin
         case (w)
            W1: enables_n = 4'hd;
            W2: enables_n = 4'hc;
            default: enables_n = 4'h0;
         endcase
      end
   endfunction

   // ======================================================
   // pin synchronisers
   reg sel_m, sel_s, sel_p;
   reg clk_m, clk_s, clk_p;
   reg [3:0] io_m, io_s;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sel_m <= 1'b1;
         sel_s <= 1'b1;
         sel_p <= 1'b1;
         clk_m <= 1'b0;
         clk_s <= 1'b0;
         clk_p <= 1'b0;
         io_m <= 4'h0;
         io_s <= 4'h0;
      end else begin
         sel_m <= spi_sel_n;
         sel_s <= sel_m;
         sel_p <= sel_s;
         clk_m <= spi_clk;
         clk_s <= clk_m;
         clk_p <= clk_s;
         io_m <= io_in;
         io_s <= io_m;
      end
   end
   wire sel_fall = sel_p & ~sel_s;
   wire sel_rise = ~sel_p & sel_s;
   wire active = ~sel_s;
   wire rise = active & clk_s & ~clk_p;
   wire fall = active & ~clk_s & clk_p;
   // ======================================================
   // status state
   reg [7:2] nv_lo_q;
   reg [1:0] nv_hi_q;
   reg wlf_q;
   reg wip_q;
   reg [23:0] tw_cnt_q;
   wire busy = wip_q | prog_busy;
   wire four_lane_enable = nv_hi_q[`SFSR_QE_BIT];
   wire [7:0] stat_lo = {nv_lo_q, wlf_q, busy};
   wire [7:0] stat_hi = {6'h00, nv_hi_q};
   // ======================================================
   // sequencer state
   reg [3:0] st_q;
   reg [4:0] cnt_q;
   reg [7:0] op_q;
   reg [15:0] wd_q;
   reg [23:0] addr_q;
   reg [7:0] mode_q;
   reg cont_q;
   reg dio_q;
   reg dmy_q;
   reg hi_q;
   reg [1:0] ow_q;
   reg [2:0] ph_q;
   reg [7:0] ob_q;
   wire [7:0] op_nx = {op_q[6:0], io_s[0]};
   wire [23:0] addr_nx = dio_q ? {addr_q[21:0], io_s[1], io_s[0]}
                               : {addr_q[22:0], io_s[0]};
   wire [4:0] addr_step = dio_q ? 5'd2 : 5'd1;
   wire [7:0] mode_nx = {mode_q[5:0], io_s[1], io_s[0]};
   // ======================================================
   // array fetch path
   reg fetch_on_q;
   reg pend_q;
   reg drop_q;
   reg [23:0] fa_q;
   wire buf_valid;
   wire [7:0] buf_data;
   wire pop = fall & (st_q == S_DATA) & (ph_q == 3'd0);
   wire hs = arr_valid & arr_ready;
   sfsr_buf #(.W(8)) u_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .flush(sel_rise),
      .in_valid(arr_valid & ~drop_q),
      .in_data(arr_data),
      .in_ready(arr_ready),
      .out_valid(buf_valid),
      .out_data(buf_data),
      .out_ready(pop)
   );

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         arr_req <= 1'b0;
         arr_addr <= 24'h000000;
         pend_q <= 1'b0;
         drop_q <= 1'b0;
      end else begin
         arr_req <= 1'b0;
         if (hs) begin
            pend_q <= 1'b0;
            drop_q <= 1'b0;
         end
         if (sel_rise & pend_q & ~hs)
            drop_q <= 1'b1;
         if (fetch_on_q & ~sel_rise & ~pend_q & ~drop_q & arr_ready) begin
            arr_req <= 1'b1;
            arr_addr <= fa_q;
            pend_q <= 1'b1;
         end
      end
   end

   // ======================================================
   // instruction sequencer
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
         cnt_q <= 5'd0;
         op_q <= 8'h00;
         wd_q <= 16'h0000;
         addr_q <= 24'h000000;
         mode_q <= 8'h00;
         cont_q <= 1'b0;
         dio_q <= 1'b0;
         dmy_q <= 1'b0;
         hi_q <= 1'b0;
         ow_q <= W1;
         ph_q <= 3'd0;
         ob_q <= 8'h00;
         fetch_on_q <= 1'b0;
         fa_q <= 24'h000000;
         io_out <= 4'h0;
         io_oe_n <= 4'hf;
         nv_lo_q <= 6'h00;
         nv_hi_q <= 2'h0;
         wlf_q <= 1'b0;
         wip_q <= 1'b0;
         tw_cnt_q <= 24'h000000;
         status_word_low <= `SFSR_LO_RESET;
         status_word_high <= `SFSR_HI_RESET;
      end else begin
         status_word_low <= stat_lo;
         status_word_high <= stat_hi;
         if (wip_q) begin
            if (tw_cnt_q == 24'h000001) begin
               wip_q <= 1'b0;
               wlf_q <= 1'b0;
            end
            tw_cnt_q <= tw_cnt_q - 24'h000001;
         end
         if (fetch_on_q & ~pend_q & ~drop_q & arr_ready)
            fa_q <= fa_q + 24'h000001;
         if (sel_fall) begin
            cnt_q <= 5'd0;
            op_q <= 8'h00;
            ph_q <= 3'd0;
            if (cont_q) begin
               st_q <= S_ADDR;
               dio_q <= 1'b1;
               dmy_q <= 1'b0;
               ow_q <= W2;
               if (busy)
                  st_q <= S_IGN;
            end else
               st_q <= S_OP;
         end else if (sel_rise) begin
            st_q <= S_IDLE;
            fetch_on_q <= 1'b0;
            io_oe_n <= 4'hf;
            if (st_q == S_END && op_q == `SFSR_OP_WR_EN)
               wlf_q <= 1'b1;
            if (st_q == S_END && op_q == `SFSR_OP_WR_DIS)
               wlf_q <= 1'b0;
            if (st_q == S_WRS && (cnt_q == `SFSR_WR_SHORT || cnt_q == `SFSR_WR_LONG)) begin
               wip_q <= 1'b1;
               tw_cnt_q <= TW_CYC;
               if (cnt_q == `SFSR_WR_SHORT) begin
                  nv_lo_q <= wd_q[7:2] & NV_LO[7:2];
                  nv_hi_q <= 2'h0;
               end else begin
                  nv_lo_q <= wd_q[15:10] & NV_LO[7:2];
                  nv_hi_q <= wd_q[1:0] & NV_HI[1:0];
               end
            end
         end else if (rise) begin
            case (st_q)
               S_OP: begin
                  op_q <= op_nx;
                  cnt_q <= cnt_q + 5'd1;
                  if (cnt_q == 5'd7) begin
                     cnt_q <= 5'd0;
                     dio_q <= 1'b0;
                     dmy_q <= 1'b1;
                     case (op_nx)
                        `SFSR_OP_STAT_LO, `SFSR_OP_STAT_HI: begin
                           st_q <= S_STAT;
                           hi_q <= (op_nx == `SFSR_OP_STAT_HI);
                           ow_q <= W1;
                        end
                        `SFSR_OP_STAT_WR:
                           st_q <= (wlf_q & ~busy) ? S_WRS : S_IGN;
                        `SFSR_OP_WR_EN, `SFSR_OP_WR_DIS:
                           st_q <= S_END;
                        `SFSR_OP_READ: begin
                           st_q <= busy ? S_IGN : S_ADDR;
                           dmy_q <= 1'b0;
                           ow_q <= W1;
                        end
                        `SFSR_OP_FAST: begin
                           st_q <= busy ? S_IGN : S_ADDR;
                           ow_q <= W1;
                        end
                        `SFSR_OP_DUAL_OUT: begin
                           st_q <= busy ? S_IGN : S_ADDR;
                           ow_q <= W2;
                        end
                        `SFSR_OP_QUAD_OUT: begin
                           st_q <= (busy | ~four_lane_enable) ? S_IGN : S_ADDR;
                           ow_q <= W4;
                        end
                        `SFSR_OP_DUAL_IO: begin
                           st_q <= busy ? S_IGN : S_ADDR;
                           dio_q <= 1'b1;
                           dmy_q <= 1'b0;
                           ow_q <= W2;
                        end
                        default: st_q <= S_IGN;
                     endcase
                  end
               end
               S_ADDR: begin
                  addr_q <= addr_nx;
                  cnt_q <= cnt_q + addr_step;
                  if (cnt_q + addr_step == `SFSR_ADDR_BITS) begin
                     cnt_q <= 5'd0;
                     fa_q <= addr_nx;
                     fetch_on_q <= 1'b1;
                     st_q <= dio_q ? S_MODE : (dmy_q ? S_DUMMY : S_DATA);
                  end
               end
               S_MODE: begin
                  mode_q <= mode_nx;
                  cnt_q <= cnt_q + 5'd1;
                  if (cnt_q == `SFSR_MODE_CLKS - 5'd1) begin
                     cont_q <= (mode_nx[7:4] == `SFSR_MODE_KEEP);
                     st_q <= S_DATA;
                  end
               end
               S_DUMMY: begin
                  cnt_q <= cnt_q + 5'd1;
                  if (cnt_q == `SFSR_DUMMY_CLKS - 5'd1)
                     st_q <= S_DATA;
               end
               S_WRS: begin
                  wd_q <= {wd_q[14:0], io_s[0]};
                  if (cnt_q != `SFSR_WR_OVER)
                     cnt_q <= cnt_q + 5'd1;
               end
               S_END: st_q <= S_IGN;
               default: st_q <= st_q;
            endcase
         end else if (fall && (st_q == S_STAT || st_q == S_DATA)) begin
            // one beat per falling edge, new byte when phase wraps
            ph_q <= ph_q + (3'd1 << ow_q);
            io_oe_n <= enables_n(ow_q);
            if (ph_q == 3'd0) begin
               if (st_q == S_STAT) begin
                  ob_q <= hi_q ? stat_hi : stat_lo;
                  io_out <= lanes(hi_q ? stat_hi : stat_lo, 3'd0, W1);
               end else begin
                  ob_q <= buf_data;
                  io_out <= lanes(buf_data, 3'd0, ow_q);
               end
            end else
               io_out <= lanes(ob_q, ph_q, ow_q);
         end
      end
   end
endmodule // sfsr_core
`default_nettype wire

// File: rtl/sfsr_map.vh
// constants for the serial flash status and read path
`ifndef SFSR_MAP_VH
`define SFSR_MAP_VH
// ======================================================
// instruction codes
`define SFSR_OP_STAT_LO 8'h05
`define SFSR_OP_STAT_HI 8'h35
`define SFSR_OP_STAT_WR 8'h01
`define SFSR_OP_WR_EN 8'h06
`define SFSR_OP_WR_DIS 8'h04
`define SFSR_OP_READ 8'h03
`define SFSR_OP_FAST 8'h0b
`define SFSR_OP_DUAL_OUT 8'h3b
`define SFSR_OP_QUAD_OUT 8'h6b
`define SFSR_OP_DUAL_IO 8'hbb
// ======================================================
// status word fields
`define SFSR_BUSY_BIT 0
`define SFSR_WLF_BIT 1
`define SFSR_NV_LO_MASK 8'hfc
`define SFSR_NV_HI_MASK 8'h03
`define SFSR_LOCK1_BIT 0
`define SFSR_QE_BIT 1
`define SFSR_LO_RESET 8'h00
`define SFSR_HI_RESET 8'h00
// ======================================================
// sequence figures
`define SFSR_ADDR_BITS 5'd24
`define SFSR_DUMMY_CLKS 5'd8
`define SFSR_MODE_CLKS 5'd4
`define SFSR_WR_SHORT 5'd8
`define SFSR_WR_LONG 5'd16
`define SFSR_WR_OVER 5'd17
`define SFSR_MODE_KEEP 4'ha
// ======================================================
// timing
`define SFSR_CLK_MHZ 25
`define SFSR_TW_US 10000
`define SFSR_TW_CYC 24'd250000
`endif

// File: test/sfsr_core_assertions.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ns
`default_nettype none
module sfsr_chk (
   input wire mclk,
   input wire rst_n,
   input wire spi_sel_n,
   input wire spi_clk,
   input wire [3:0] io_out,
   input wire [3:0] io_oe_n,
   input wire prog_busy,
   input wire arr_req,
   input wire [7:0] status_word_low,
   input wire [7:0] status_word_high
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ==========
   // port relations
   property p_hi_zero; status_word_high[7:2] == 6'h00; endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("spare status bits set");
   property p_lo_rest; $changed(status_word_low[7:2]) |-> spi_sel_n; endproperty
   a_lo_rest: assert property (p_lo_rest) else $error("status changed in frame");
   property p_wlf_drop; $fell(status_word_low[0]) |-> !status_word_low[1]; endproperty
   a_wlf_drop: assert property (p_wlf_drop) else $error("latch kept after cycle");
   property p_req_pulse; arr_req |=> !arr_req; endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("fetch request too long");
   property p_idle_oe; spi_sel_n [*6] |=> io_oe_n == 4'hf; endproperty
   a_idle_oe: assert property (p_idle_oe) else $error("drive while deselected");
   property p_oe_code; io_oe_n == 4'hf || io_oe_n == 4'hd || io_oe_n == 4'hc || io_oe_n == 4'h0; endproperty
   a_oe_code: assert property (p_oe_code) else $error("odd lane enable set");
   property p_quad_qe; io_oe_n == 4'h0 |-> status_word_high[1]; endproperty
   a_quad_qe: assert property (p_quad_qe) else $error("quad drive without lane enable");
   property p_busy_noreq; prog_busy && $past(prog_busy, 8) |-> !arr_req; endproperty
   a_busy_noreq: assert property (p_busy_noreq) else $error("fetch while busy");
   property p_out_fall; !spi_sel_n && !$past(spi_sel_n, 4) && $changed(io_out) |-> !$past(spi_clk, 2); endproperty
   a_out_fall: assert property (p_out_fall) else $error("output moved off fall");
endmodule // sfsr_chk
bind sfsr_core sfsr_chk i_sfsr_chk (.mclk(mclk), .rst_n(rst_n), .spi_sel_n(spi_sel_n), .spi_clk(spi_clk),
   .io_out(io_out), .io_oe_n(io_oe_n), .prog_busy(prog_busy), .arr_req(arr_req),
   .status_word_low(status_word_low), .status_word_high(status_word_high));
`default_nettype wire

// File: test/sfsr_host.sv
// host controller model driving select, clock and data lines
`timescale 1ns/1ns
`default_nettype none
module sfsr_host (
   input wire logic mclk,
   input wire logic [3:0] io,
   output logic sel_n,
   output logic sclk,
   output logic [3:0] h_do,
   output logic [3:0] h_oe
);
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      h_do = 4'h0;
      h_oe = 4'h0;
   end
   // ==========
   // link phases
   task automatic half();
      repeat (4) @(negedge mclk);
   endtask
   // n clocks over w lanes, tx left aligned, changes on falls
   task automatic bits(input logic [31:0] tx, input int n, input int w, input bit d, output logic [31:0] r);
      logic [31:0] t;
      logic [3:0] s;
      t = tx;
      r = 32'h0;
      for (int i = 0; i < n; i++) begin
         h_oe = d ? 4'((1 << w) - 1) : 4'h0;
         h_do = 4'(t >> (32 - w));
         t = t << w;
         half();
         sclk = 1'b1;
         half();
         s = (w == 1) ? {3'h0, io[1]} : (w == 2) ? {2'h0, io[1:0]} : io;
         r = (r << w) | {28'h0, s};
         sclk = 1'b0;
      end
   endtask
   // opcode 00 means none, for continuous mode
   task automatic frame(input logic [7:0] op, input logic [31:0] a, input int an, input int aw, input int dm,
      input int w, input int nd, output logic [31:0] r);
      sel_n = 1'b0;
      half();
      if (op != 8'h00) bits({op, 24'h0}, 8, 1, 1'b1, r);
      if (an > 0) bits(a << (32 - an * aw), an, aw, 1'b1, r);
      if (dm > 0) bits(32'h0, dm, 1, 1'b0, r);
      bits(32'h0, nd, w, 1'b0, r);
   endtask
   task automatic stop();
      half();
      h_oe = 4'h0;
      sel_n = 1'b1;
      repeat (8) @(negedge mclk);
   endtask
endmodule // sfsr_host
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the status and read sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic mclk, rst_n, prog_busy, arr_req, arr_ready, sel_n, sclk;
   logic arr_valid = 1'b0, hs = 1'b0, tgl = 1'b0;
   logic [3:0] io_out, io_oe_n, h_do, h_oe;
   logic [7:0] arr_data = 8'h00;
   logic [7:0] sw_lo, sw_hi;
   logic [23:0] arr_addr;
   wire [3:0] io_in;
   int failures, total_checks;
   sfsr_core #(.TW_CYC(24'd400)) i_sfsr_core (.mclk(mclk), .rst_n(rst_n), .spi_sel_n(sel_n), .spi_clk(sclk),
      .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .prog_busy(prog_busy), .arr_req(arr_req),
      .arr_addr(arr_addr), .arr_valid(arr_valid), .arr_data(arr_data), .arr_ready(arr_ready),
      .status_word_low(sw_lo), .status_word_high(sw_hi));
   sfsr_host i_sfsr_host (.mclk(mclk), .io(io_in), .sel_n(sel_n), .sclk(sclk), .h_do(h_do), .h_oe(h_oe));
   // released lines toggle so a stale level never passes
   assign io_in = (~io_oe_n & io_out) | (io_oe_n & h_oe & h_do) | (io_oe_n & ~h_oe & {4{tgl}});
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ==========
   // array model
   function automatic logic [7:0] dat(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
   endfunction
   always @(posedge mclk) tgl <= ~tgl;
   always @(posedge mclk) hs <= arr_valid & arr_ready;
   always @(negedge mclk) begin
      if (arr_req) begin
         arr_valid <= 1'b1;
         arr_data <= dat(arr_addr);
      end else if (hs) arr_valid <= 1'b0;
   end
   // ==========
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [31:0] d, input int n);
      logic [31:0] r;
      i_sfsr_host.frame(op, d, n, 1, 0, 1, 0, r);
      i_sfsr_host.stop();
   endtask
   task automatic rs(input logic [7:0] op, input logic [7:0] e);
      logic [31:0] r;
      i_sfsr_host.frame(op, 32'h0, 0, 1, 0, 1, 24, r);
      chk(r, {8'h00, e, e, e});
      chk(io_oe_n, 4'hd);
      i_sfsr_host.stop();
   endtask
   task automatic rd(input logic [7:0] op, input logic [31:0] a, input int an, input int aw, input int dm,
      input int w, input logic [3:0] oe, input bit ok);
      logic [31:0] r;
      logic [23:0] b;
      b = (an * aw == 32) ? a[31:8] : a[23:0];
      i_sfsr_host.frame(op, a, an, aw, dm, w, 32 / w, r);
      chk(io_oe_n, ok ? oe : 4'hf);
      if (ok) chk(r, {dat(b), dat(b + 24'd1), dat(b + 24'd2), dat(b + 24'd3)});
      i_sfsr_host.stop();
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 1000; i++) begin
         @(negedge mclk);
         if (sw_lo[0] === 1'b0) return;
      end
      failures++;
      test_done();
   endtask
   // ==========
   // scenarios
   task automatic t_reset();
      chk(sw_lo, 8'h00);
      chk(sw_hi, 8'h00);
      rs(8'h05, 8'h00);
      rs(8'h35, 8'h00);
   endtask
   task automatic t_write_long();
      cmd(8'h06, 32'h0, 0);
      chk(sw_lo, 8'h02);
      cmd(8'h01, 32'hffff, 16);
      rs(8'h05, 8'hff);
      wait_idle();
      chk(sw_lo, 8'hfc);
      rs(8'h35, 8'h03);
   endtask
   task automatic t_reads();
      rd(8'h03, 32'h01fffe, 24, 1, 0, 1, 4'hd, 1'b1);
      rd(8'h0b, 32'h12345c, 24, 1, 8, 1, 4'hd, 1'b1);
      rd(8'h3b, 32'h00a0ff, 24, 1, 8, 2, 4'hc, 1'b1);
      rd(8'h6b, 32'h0003fe, 24, 1, 8, 4, 4'h0, 1'b1);
   endtask
   task automatic t_cont();
      rd(8'hbb, 32'h2468aca5, 16, 2, 0, 2, 4'hc, 1'b1);
      rd(8'h00, 32'h13579bff, 16, 2, 0, 2, 4'hc, 1'b1);
      rd(8'h03, 32'h000100, 24, 1, 0, 1, 4'hd, 1'b1);
   endtask
   task automatic t_write_bad();
      cmd(8'h04, 32'h0, 0);
      cmd(8'h01, 32'h0, 16);
      chk(sw_lo, 8'hfc);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h01, 32'h0, 9);
      chk(sw_lo & 8'hfd, 8'hfc);
      chk(sw_hi, 8'h03);
   endtask
   task automatic t_write_short();
      cmd(8'h06, 32'h0, 0);
      cmd(8'h01, 32'h84, 8);
      wait_idle();
      chk(sw_lo, 8'h84);
      chk(sw_hi, 8'h00);
   endtask
   task automatic t_refused();
      rd(8'h6b, 32'h10, 24, 1, 8, 4, 4'h0, 1'b0);
      rd(8'h9f, 32'h10, 24, 1, 0, 1, 4'hd, 1'b0);
      prog_busy = 1'b1;
      repeat (10) @(negedge mclk);
      rd(8'h03, 32'h10, 24, 1, 0, 1, 4'hd, 1'b0);
      prog_busy = 1'b0;
      repeat (10) @(negedge mclk);
      chk(sw_lo, 8'h84);
   endtask
   initial begin
      rst_n = 1'b0;
      prog_busy = 1'b0;
      failures = 0;
      total_checks = 0;
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      repeat (8) @(negedge mclk);
      t_reset();
      t_write_long();
      t_reads();
      t_cont();
      t_write_bad();
      t_write_short();
      t_refused();
      test_done();
   end
endmodule // testbench
`default_nettype wire
